// file: lcd_drive_timing_regs.svh
/*
 Register offsets, field positions, reset values and divider counts
 for the LCD drive timing and ladder power block.
 Assumes a byte-wide register port with a five-bit word address.
*/
// Behaviour
// - Ladder sits in level A for a set span after each transition, then level B
// - Three-bit A length counts 32 kHz ticks; zero keeps ladder in level B
// - Waveform type 0: N ticks in A, then 16 minus N in B
// - Waveform type 1: N ticks in A, then 32 minus N in B
// - Bits 7..6 give ladder power in interval A: off, low, medium, high
// - Bits 5..4 give ladder power in interval B, same encoding
// - A and B spans are timed by the five-bit 32 kHz to 1 kHz prescaler
// - Contrast ladder is off and open while the module is inactive
// - Internal bias reference is off while the module is inactive
// - With no internal reference selected the contrast circuit is disabled
// - Idle bit set and ladder in level B turns the reference buffer off
// - Fixed voltage reference is switched on automatically when needed
// - Each external bias pin has its own independent connect bit
// - Common count field selects commons 0, 1..0, 2..0 or 3..0
// - A common driver pin ignores its direction bit; idle pins follow it
// - Segment enable set makes the pin a driver, overriding direction
// - After reset all segment-capable pins are ordinary I/O
// - One pixel per data bit; unused bits are plain storage
// - Frame rate is source over 128 times (prescale+1), or 96 times for third mux
// - Source clock is system clock over 256, crystal or internal oscillator
// - Reference ladder is off while inactive, whatever the power fields say
// - Four-bit frame prescaler divides by 1 through 16
`ifndef LCD_DRIVE_TIMING_REGS_SVH
`define LCD_DRIVE_TIMING_REGS_SVH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define OFS_MAIN 5'h00
`define OFS_PRESCALE 5'h01
`define OFS_BIASREF 5'h02
`define OFS_CONTRAST 5'h03
`define OFS_LADDER 5'h04
`define OFS_SEGEN0 5'h05
`define OFS_SEGEN1 5'h06
`define OFS_SEGEN2 5'h07
`define OFS_PIXEL0 5'h08
`define OFS_PIXEL_LAST 5'h13
`define OFS_STATUS 5'h14
`define PIXEL_REGS 12

// ----------------------------------------
// Fields
// ----------------------------------------
`define MAIN_EN 7
`define MAIN_WFT 6
`define MAIN_ACT 5
`define MAIN_CS_HI 3
`define MAIN_CS_LO 2
`define MAIN_MUX_HI 1
`define MAIN_MUX_LO 0
`define REF_EN 7
`define REF_FVR 6
`define REF_IDLE 5
`define REF_PIN_HI 3
`define REF_PIN_LO 1
`define LAD_AP_HI 7
`define LAD_AP_LO 6
`define LAD_BP_HI 5
`define LAD_BP_LO 4
`define LAD_AT_HI 2
`define LAD_AT_LO 0

// ----------------------------------------
// Write masks and reset values
// ----------------------------------------
`define MASK_MAIN 8'hdf
`define MASK_PRESCALE 8'h0f
`define MASK_BIASREF 8'hee
`define MASK_CONTRAST 8'h07
`define MASK_LADDER 8'hf7
`define RST_BYTE 8'h00
`define RST_SEGEN 24'h000000

// ----------------------------------------
// Codes and counts
// ----------------------------------------
`define CS_SYSDIV 2'b00
`define CS_XTAL 2'b01
`define MUX_STATIC 2'b00
`define MUX_HALF 2'b01
`define MUX_THIRD 2'b10
`define PWR_OFF 2'b00
`define SYS_DIV_LAST 8'hff
`define PRE_LAST 5'h1f
`define SLOT_LAST_QUAD 2'h3
`define SLOT_LAST_THIRD 2'h2

`endif

// file: lcd_drive_timing_pkg.sv
/*
 Types shared by the LCD drive timing block.
 Assumes the register header is compiled alongside.
*/
package lcd_drive_timing_pkg;

	// ----------------------------------------
	// Ladder power phase
	// ----------------------------------------
	typedef enum logic {LADDER_B, LADDER_A} ladder_phase_e;

endpackage

// file: lcd_drive_timing.sv
/*
 LCD drive timing: source clock select, frame stepping, ladder power
 switching, reference gating, pin function select and pixel storage.
 Assumes a same-clock register master and asynchronous oscillator pins.
*/
`timescale 1ns/1ns
`include "lcd_drive_timing_regs.svh"

module lcd_drive_timing (
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Register port
	input wire logic [4:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata,
	// Low-rate clock pins
	input wire logic timerCrystalOsc,
	input wire logic lowFreqInternalOsc,
	// Port direction bits, one means input
	input wire logic [23:0] segPortDirectionBits,
	input wire logic [3:0] comPortDirectionBits,
	// Pin function
	output logic [23:0] segmentPinEnables,
	output logic [23:0] segPinOe,
	output logic [3:0] comPinOe,
	output logic [3:0] commonActive,
	// Drive timing
	output logic moduleActiveFlag,
	output logic [1:0] commonPhase,
	output logic [23:0] segPixelLevel,
	output logic frameStart,
	// Analog controls
	output logic [1:0] ladderPower,
	output logic contrastLadderOn,
	output logic [2:0] contrastTapSelect,
	output logic internalRefOn,
	output logic refFromFvr,
	output logic fvrEnable,
	output logic fvrBufferOn,
	output logic [2:0] externalBiasPin
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic inIntervalA(input logic [2:0] len, input logic waveform_type_select,
			input logic [4:0] pre);
		logic [4:0] span;
		span = waveform_type_select ? pre : {1'b0, pre[3:0]};
		return (len != 3'h0) && (span < {2'b00, len});
	endfunction

	function automatic logic [3:0] commonMask(input logic [1:0] mux, input logic act);
		logic [3:0] m;
		case (mux)
			`MUX_STATIC: m = 4'h1;
			`MUX_HALF: m = 4'h3;
			`MUX_THIRD: m = 4'h7;
			default: m = 4'hf;
		endcase
		return act ? m : 4'h0;
	endfunction

	function automatic logic [1:0] phaseOf(input logic [1:0] slot, input logic [1:0] mux);
		logic [1:0] p;
		case (mux)
			`MUX_STATIC: p = 2'h0;
			`MUX_HALF: p = {1'b0, slot[0]};
			default: p = slot;
		endcase
		return p;
	endfunction

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	logic [7:0] lcdMainControl, next_lcdMainControl;
	logic [7:0] framePrescaleValue, next_framePrescaleValue;
	logic [7:0] biasReferenceControl, next_biasReferenceControl;
	logic [7:0] contrastCtl, next_contrastCtl;
	logic [7:0] refLadderPowerControl, next_refLadderPowerControl;
	logic [23:0] next_segmentPinEnables;
	logic [7:0] next_regRdata;
	logic [7:0] pixelBits [`PIXEL_REGS];
	logic [4:0] pixOfs;
	logic pixHit;
	lcd_drive_timing_pkg::ladder_phase_e ladderPhase, next_ladderPhase;

	logic moduleActive;
	logic enableBit, wftBit;
	logic [1:0] clockSelect, commonCountSelect;
	logic [3:0] lpValue;
	logic [2:0] aLength;
	logic [1:0] aPower, bPower;

	assign enableBit = lcdMainControl[`MAIN_EN];
	assign wftBit = lcdMainControl[`MAIN_WFT];
	assign clockSelect = lcdMainControl[`MAIN_CS_HI:`MAIN_CS_LO];
	assign commonCountSelect = lcdMainControl[`MAIN_MUX_HI:`MAIN_MUX_LO];
	assign lpValue = framePrescaleValue[3:0];
	assign aLength = refLadderPowerControl[`LAD_AT_HI:`LAD_AT_LO];
	assign aPower = refLadderPowerControl[`LAD_AP_HI:`LAD_AP_LO];
	assign bPower = refLadderPowerControl[`LAD_BP_HI:`LAD_BP_LO];
	assign pixOfs = regAddr - `OFS_PIXEL0;
	assign pixHit = (regAddr >= `OFS_PIXEL0) && (regAddr <= `OFS_PIXEL_LAST);

	always_comb begin
		next_lcdMainControl = lcdMainControl;
		next_framePrescaleValue = framePrescaleValue;
		next_biasReferenceControl = biasReferenceControl;
		next_contrastCtl = contrastCtl;
		next_refLadderPowerControl = refLadderPowerControl;
		next_segmentPinEnables = segmentPinEnables;
		next_regRdata = `RST_BYTE;
		if (regWr) begin
			case (regAddr)
				`OFS_MAIN: next_lcdMainControl = regWdata & `MASK_MAIN;
				`OFS_PRESCALE: next_framePrescaleValue = regWdata & `MASK_PRESCALE;
				`OFS_BIASREF: next_biasReferenceControl = regWdata & `MASK_BIASREF;
				`OFS_CONTRAST: next_contrastCtl = regWdata & `MASK_CONTRAST;
				`OFS_LADDER: next_refLadderPowerControl = regWdata & `MASK_LADDER;
				`OFS_SEGEN0: next_segmentPinEnables[7:0] = regWdata;
				`OFS_SEGEN1: next_segmentPinEnables[15:8] = regWdata;
				`OFS_SEGEN2: next_segmentPinEnables[23:16] = regWdata;
				default: next_regRdata = `RST_BYTE;
			endcase
		end
		if (regRd) begin
			case (regAddr)
				`OFS_MAIN: begin
					next_regRdata = lcdMainControl;
					next_regRdata[`MAIN_ACT] = moduleActive;
				end
				`OFS_PRESCALE: next_regRdata = framePrescaleValue;
				`OFS_BIASREF: next_regRdata = biasReferenceControl;
				`OFS_CONTRAST: next_regRdata = contrastCtl;
				`OFS_LADDER: next_regRdata = refLadderPowerControl;
				`OFS_SEGEN0: next_regRdata = segmentPinEnables[7:0];
				`OFS_SEGEN1: next_regRdata = segmentPinEnables[15:8];
				`OFS_SEGEN2: next_regRdata = segmentPinEnables[23:16];
				`OFS_STATUS: next_regRdata = {5'h00, commonPhase,
					ladderPhase == lcd_drive_timing_pkg::LADDER_A};
				default: next_regRdata = pixHit ? pixelBits[pixOfs[3:0]] : `RST_BYTE;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			lcdMainControl <= `RST_BYTE;
			framePrescaleValue <= `RST_BYTE;
			biasReferenceControl <= `RST_BYTE;
			contrastCtl <= `RST_BYTE;
			refLadderPowerControl <= `RST_BYTE;
			segmentPinEnables <= `RST_SEGEN;
			regRdata <= `RST_BYTE;
		end else begin
			lcdMainControl <= next_lcdMainControl;
			framePrescaleValue <= next_framePrescaleValue;
			biasReferenceControl <= next_biasReferenceControl;
			contrastCtl <= next_contrastCtl;
			refLadderPowerControl <= next_refLadderPowerControl;
			segmentPinEnables <= next_segmentPinEnables;
			regRdata <= next_regRdata;
		end
	end

	// Pixel storage keeps its contents across reset, like display RAM
	always_ff @(posedge mclk) begin
		if (regWr && pixHit) begin
			pixelBits[pixOfs[3:0]] <= regWdata;
		end
	end

	// ----------------------------------------
	// Source clock and prescalers
	// ----------------------------------------
	logic [1:0] oscMeta, oscSync, oscLast;
	logic [1:0] next_oscLast;
	logic [7:0] sysDiv, next_sysDiv;
	logic [4:0] preCount, next_preCount;
	logic [3:0] lpCount, next_lpCount;
	logic [1:0] slotCount, next_slotCount;
	logic [1:0] slotLast;
	logic tick32, tick1k, stepTick;
	logic next_moduleActive;

	assign next_oscLast = oscSync;
	assign slotLast = (commonCountSelect == `MUX_THIRD) ? `SLOT_LAST_THIRD : `SLOT_LAST_QUAD;
	assign tick1k = tick32 && (preCount == `PRE_LAST);
	assign stepTick = tick1k && (lpCount == lpValue);
	assign next_moduleActive = enableBit;

	always_comb begin
		case (clockSelect)
			`CS_SYSDIV: tick32 = (sysDiv == `SYS_DIV_LAST);
			`CS_XTAL: tick32 = oscSync[0] & ~oscLast[0];
			default: tick32 = oscSync[1] & ~oscLast[1];
		endcase
		next_sysDiv = sysDiv + 8'h01;
		next_preCount = preCount;
		next_lpCount = lpCount;
		next_slotCount = slotCount;
		if (!moduleActive) begin
			next_preCount = 5'h00;
			next_lpCount = 4'h0;
			next_slotCount = 2'h0;
		end else begin
			if (tick32) begin
				next_preCount = preCount + 5'h01;
			end
			if (tick1k) begin
				next_lpCount = (lpCount == lpValue) ? 4'h0 : lpCount + 4'h1;
			end
			if (stepTick) begin
				next_slotCount = (slotCount == slotLast) ? 2'h0 : slotCount + 2'h1;
			end
		end
	end

	// Pin levels cross two flops before the edge detect
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			oscMeta <= 2'h0;
			oscSync <= 2'h0;
			oscLast <= 2'h0;
			sysDiv <= 8'h00;
			preCount <= 5'h00;
			lpCount <= 4'h0;
			slotCount <= 2'h0;
			moduleActive <= 1'b0;
		end else begin
			oscMeta <= {lowFreqInternalOsc, timerCrystalOsc};
			oscSync <= oscMeta;
			oscLast <= next_oscLast;
			sysDiv <= next_sysDiv;
			preCount <= next_preCount;
			lpCount <= next_lpCount;
			slotCount <= next_slotCount;
			moduleActive <= next_moduleActive;
		end
	end

	// ----------------------------------------
	// Drive outputs and ladder control
	// ----------------------------------------
	logic [3:0] rowBase;
	logic [1:0] next_ladderPower;
	logic refEnable, refSrcFvr, refIdle;
	logic next_fvrEnable;

	assign refEnable = biasReferenceControl[`REF_EN];
	assign refSrcFvr = biasReferenceControl[`REF_FVR];
	assign refIdle = biasReferenceControl[`REF_IDLE];
	assign rowBase = {1'b0, commonPhase, 1'b0} + {2'b00, commonPhase};
	assign next_fvrEnable = moduleActive && refEnable && refSrcFvr;

	always_comb begin
		next_ladderPhase = lcd_drive_timing_pkg::LADDER_B;
		if (moduleActive && inIntervalA(aLength, wftBit, preCount)) begin
			next_ladderPhase = lcd_drive_timing_pkg::LADDER_A;
		end
		// Power fields are ignored while inactive so the ladder never floats on
		if (!moduleActive) begin
			next_ladderPower = `PWR_OFF;
		end else if (ladderPhase == lcd_drive_timing_pkg::LADDER_A) begin
			next_ladderPower = aPower;
		end else begin
			next_ladderPower = bPower;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ladderPhase <= lcd_drive_timing_pkg::LADDER_B;
			ladderPower <= `PWR_OFF;
			contrastLadderOn <= 1'b0;
			contrastTapSelect <= 3'h0;
			internalRefOn <= 1'b0;
			refFromFvr <= 1'b0;
			fvrEnable <= 1'b0;
			fvrBufferOn <= 1'b0;
			externalBiasPin <= 3'h0;
			commonActive <= 4'h0;
			commonPhase <= 2'h0;
			segPixelLevel <= 24'h000000;
			frameStart <= 1'b0;
			segPinOe <= 24'h000000;
			comPinOe <= 4'h0;
			moduleActiveFlag <= 1'b0;
		end else begin
			ladderPhase <= next_ladderPhase;
			ladderPower <= next_ladderPower;
			contrastLadderOn <= moduleActive && refEnable;
			contrastTapSelect <= contrastCtl[2:0];
			internalRefOn <= moduleActive && refEnable;
			refFromFvr <= refSrcFvr;
			fvrEnable <= next_fvrEnable;
			fvrBufferOn <= next_fvrEnable &&
				!(refIdle && ladderPhase == lcd_drive_timing_pkg::LADDER_B);
			externalBiasPin <= biasReferenceControl[`REF_PIN_HI:`REF_PIN_LO];
			commonActive <= commonMask(commonCountSelect, moduleActive);
			commonPhase <= phaseOf(slotCount, commonCountSelect);
			segPixelLevel <= {pixelBits[rowBase + 4'h2], pixelBits[rowBase + 4'h1],
				pixelBits[rowBase]};
			frameStart <= stepTick && (slotCount == slotLast);
			segPinOe <= segmentPinEnables | ~segPortDirectionBits;
			comPinOe <= commonMask(commonCountSelect, moduleActive) |
				~comPortDirectionBits;
			moduleActiveFlag <= moduleActive;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	a_ladder_idle_off: assert property (!moduleActive |=> ladderPower == `PWR_OFF)
		else $error("ladder powered while inactive");
	a_contrast_idle: assert property (!moduleActive |=> !contrastLadderOn)
		else $error("contrast ladder on while inactive");
	a_ref_idle_off: assert property (!moduleActive |=> !internalRefOn)
		else $error("reference on while inactive");
	a_noref_contrast: assert property (!refEnable |=> !contrastLadderOn)
		else $error("contrast on without reference");
	a_buffer_idle: assert property (
		refIdle && ladderPhase == lcd_drive_timing_pkg::LADDER_B |=> !fvrBufferOn)
		else $error("reference buffer on in level B with idle set");
	a_fvr_auto_on: assert property (
		moduleActive && refEnable && refSrcFvr |=> fvrEnable)
		else $error("fixed reference not enabled");
	a_zero_span: assert property (aLength == 3'h0 |=>
		ladderPhase == lcd_drive_timing_pkg::LADDER_B)
		else $error("level A with zero span");
	a_span_start: assert property (moduleActive && aLength != 3'h0 && preCount == 5'h00
		|=> ladderPhase == lcd_drive_timing_pkg::LADDER_A)
		else $error("no level A at transition");
	a_typea_tail: assert property (!wftBit && preCount[3:0] >= {1'b0, aLength}
		|=> ladderPhase == lcd_drive_timing_pkg::LADDER_B)
		else $error("type A level A too long");
	a_typeb_tail: assert property (wftBit && preCount >= {2'b00, aLength}
		|=> ladderPhase == lcd_drive_timing_pkg::LADDER_B)
		else $error("type B level A too long");
	a_apower_used: assert property (moduleActive &&
		ladderPhase == lcd_drive_timing_pkg::LADDER_A && $stable(aPower)
		|=> ladderPower == $past(aPower))
		else $error("wrong level A power");
	a_seg_override: assert property (!sys_rst |=>
		segPinOe == ($past(segmentPinEnables) | ~$past(segPortDirectionBits)))
		else $error("segment pin enable wrong");
	a_static_common: assert property (moduleActive && commonCountSelect == `MUX_STATIC
		|=> commonActive == 4'h1 && comPinOe[0])
		else $error("static mode commons wrong");
	a_third_slots: assert property (commonCountSelect == `MUX_THIRD && slotCount == 2'h2
		&& stepTick |=> slotCount == 2'h0)
		else $error("third mux frame not three steps");
	a_restart_span: assert property (tick1k && moduleActive |=> preCount == 5'h00)
		else $error("span counter not restarted");

	c_level_a: cover property (ladderPhase == lcd_drive_timing_pkg::LADDER_A);
	c_buffer_off: cover property (fvrEnable && !fvrBufferOn);
	c_frame_third: cover property (frameStart && commonCountSelect == `MUX_THIRD);
	c_frame_quad: cover property (frameStart && commonCountSelect == 2'b11);

endmodule

// file: lcd_glass_panel.sv
/*
 Glass panel model: latches the segment drive of each common time slice
 and counts frame boundaries.
 Assumes it shares the block's clock and sees its drive ports directly.
*/
`timescale 1ns/1ns

module lcd_glass_panel (
	// Clock
	input wire logic mclk,
	// Drive from the block
	input wire logic [3:0] commonActive,
	input wire logic [1:0] commonPhase,
	input wire logic [23:0] segPixelLevel,
	input wire logic frameStart,
	// Observed state
	output logic [95:0] rowBits,
	output logic [15:0] frameCount
);

	initial begin
		rowBits = '0;
		frameCount = 16'h0000;
	end

	// Rows latch only while a common is driven; an idle glass keeps its image
	always @(posedge mclk) begin
		if (commonActive != 4'h0) begin
			rowBits[commonPhase * 24 +: 24] <= segPixelLevel;
		end
		if (frameStart === 1'b1) begin
			frameCount <= frameCount + 16'h0001;
		end
	end

endmodule

// file: lcd_drive_timing_tb.sv
/*
 Self-checking bench for the LCD drive timing block.
 Assumes the register header and the glass panel model are compiled first.
*/
`timescale 1ns/1ns
`include "lcd_drive_timing_regs.svh"

`define CHECK(what, exp, got) begin \
	cmpCount++; \
	if ((got) !== (exp)) begin \
		failures++; \
		$display("wrong value %s expected %0h seen %0h", what, exp, got); \
	end \
end

module lcd_drive_timing_tb;

	logic mclk, sysRst, regWr, regRd, xtalOsc, lfOsc;
	logic [4:0] regAddr;
	logic [7:0] regWdata, regRdata;
	logic [23:0] segDir, segmentPinEnables, segPinOe, segPixelLevel;
	logic [3:0] comDir, comPinOe, commonActive;
	logic [1:0] commonPhase, ladderPower;
	logic moduleActiveFlag, frameStart, contrastLadderOn, internalRefOn;
	logic refFromFvr, fvrEnable, fvrBufferOn;
	logic [2:0] contrastTapSelect, externalBiasPin;
	logic [95:0] rowBits;
	logic [15:0] frameCount;
	logic [2:0] xtalCnt;
	logic [3:0] lfCnt;
	int failures, cmpCount;

	lcd_drive_timing uut (.mclk(mclk), .sys_rst(sysRst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.timerCrystalOsc(xtalOsc), .lowFreqInternalOsc(lfOsc),
		.segPortDirectionBits(segDir), .comPortDirectionBits(comDir),
		.segmentPinEnables(segmentPinEnables), .segPinOe(segPinOe), .comPinOe(comPinOe),
		.commonActive(commonActive), .moduleActiveFlag(moduleActiveFlag),
		.commonPhase(commonPhase), .segPixelLevel(segPixelLevel), .frameStart(frameStart),
		.ladderPower(ladderPower), .contrastLadderOn(contrastLadderOn),
		.contrastTapSelect(contrastTapSelect), .internalRefOn(internalRefOn),
		.refFromFvr(refFromFvr), .fvrEnable(fvrEnable), .fvrBufferOn(fvrBufferOn),
		.externalBiasPin(externalBiasPin));

	lcd_glass_panel panel (.mclk(mclk), .commonActive(commonActive),
		.commonPhase(commonPhase), .segPixelLevel(segPixelLevel), .frameStart(frameStart),
		.rowBits(rowBits), .frameCount(frameCount));

	// ----------------------------------------
	// Clock, oscillators, bus tasks
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// Crystal ticks every 8 cycles, internal oscillator every 12
	always @(posedge mclk) begin
		xtalCnt <= xtalCnt + 3'h1;
		lfCnt <= (lfCnt == 4'hb) ? 4'h0 : lfCnt + 4'h1;
		xtalOsc <= xtalCnt[2];
		lfOsc <= (lfCnt < 4'h6);
	end

	function automatic logic [7:0] pix(input int i);
		return 8'(i * 37 + 17);
	endfunction

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge mclk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask

	task automatic reg_check(input logic [4:0] a, input logic [7:0] e);
		@(posedge mclk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge mclk);
		regRd <= 1'b0;
		#1;
		`CHECK("read data", e, regRdata)
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_reset_and_map;
		`CHECK("segment enables", 24'h000000, segmentPinEnables)
		`CHECK("segment oe", ~segDir, segPinOe)
		for (int a = 0; a < 8; a++) reg_check(5'(a), 8'h00);
		wr(`OFS_MAIN, 8'h7f);
		reg_check(`OFS_MAIN, 8'h5f);
		wr(`OFS_LADDER, 8'hff);
		reg_check(`OFS_LADDER, 8'hf7);
		wr(`OFS_BIASREF, 8'hff);
		reg_check(`OFS_BIASREF, 8'hee);
		wr(`OFS_PRESCALE, 8'hff);
		reg_check(`OFS_PRESCALE, 8'h0f);
		wr(`OFS_CONTRAST, 8'hff);
		reg_check(`OFS_CONTRAST, 8'h07);
		`CHECK("contrast taps", 3'h7, contrastTapSelect)
		wr(5'h15, 8'hff);
		reg_check(5'h15, 8'h00);
		for (int i = 0; i < 12; i++) wr(5'(8 + i), pix(i));
		for (int i = 0; i < 12; i++) reg_check(5'(8 + i), pix(i));
	endtask

	task automatic test_pins;
		wr(`OFS_SEGEN0, 8'ha5);
		wr(`OFS_SEGEN1, 8'h5a);
		wr(`OFS_SEGEN2, 8'hff);
		settle(3);
		`CHECK("segment enables", 24'hff5aa5, segmentPinEnables)
		`CHECK("segment oe", 24'hff5aa5 | ~segDir, segPinOe)
	endtask

	task automatic test_inactive;
		wr(`OFS_MAIN, 8'h03);
		wr(`OFS_LADDER, 8'hf3);
		wr(`OFS_BIASREF, 8'he0);
		settle(4);
		`CHECK("ladder power", 2'h0, ladderPower)
		`CHECK("contrast on", 1'b0, contrastLadderOn)
		`CHECK("reference on", 1'b0, internalRefOn)
		`CHECK("commons", 4'h0, commonActive)
		`CHECK("module active", 1'b0, moduleActiveFlag)
		wr(`OFS_MAIN, 8'h83);
		settle(4);
		reg_check(`OFS_MAIN, 8'ha3);
		`CHECK("module active", 1'b1, moduleActiveFlag)
	endtask

	// Waveforms are periodic, so a window of whole periods gives exact counts
	task automatic ladder_case(input logic [7:0] m, input logic [7:0] l, input int wait0,
		input int win, input int expA);
		int aCnt, bCnt, bufCnt;
		aCnt = 0;
		bCnt = 0;
		bufCnt = 0;
		wr(`OFS_LADDER, l);
		wr(`OFS_MAIN, m);
		settle(wait0);
		repeat (win) begin
			if (ladderPower === 2'h3) aCnt++;
			if (ladderPower === 2'h1) bCnt++;
			if (fvrBufferOn === 1'b1) bufCnt++;
			settle(1);
		end
		`CHECK("level A cycles", expA, aCnt)
		`CHECK("level B cycles", win - expA, bCnt)
		`CHECK("buffer on cycles", expA, bufCnt)
		`CHECK("fvr enable", 1'b1, fvrEnable)
	endtask

	task automatic test_ladder;
		int lens [3];
		lens = '{0, 1, 7};
		wr(`OFS_BIASREF, 8'hea);
		for (int w = 0; w < 2; w++) begin
			foreach (lens[k]) begin
				ladder_case(8'(8'h87 | (w << 6)), 8'(8'hd0 | lens[k]), 600, 512,
					lens[k] * (w ? 16 : 32));
			end
		end
		ladder_case(8'hc3, 8'hd1, 8300, 8192, 256);
		ladder_case(8'hcb, 8'hd2, 500, 384, 24);
		`CHECK("contrast on", 1'b1, contrastLadderOn)
		`CHECK("fvr source", 1'b1, refFromFvr)
		`CHECK("bias pins", 3'b101, externalBiasPin)
		wr(`OFS_BIASREF, 8'h0a);
		settle(4);
		`CHECK("contrast on", 1'b0, contrastLadderOn)
		`CHECK("reference on", 1'b0, internalRefOn)
		`CHECK("bias pins", 3'b101, externalBiasPin)
	endtask

	task automatic test_frames;
		int frame;
		logic [15:0] f0;
		logic [3:0] mask;
		// Stop the module first so every divider except the system clock divider restarts from zero
		wr(`OFS_MAIN, 8'h00);
		for (int mux = 0; mux < 4; mux++) begin
			frame = (mux == 2 ? 3 : 4) * (mux + 1) * 256;
			mask = 4'((2 << mux) - 1);
			wr(`OFS_PRESCALE, 8'(mux));
			wr(`OFS_MAIN, 8'(8'h84 | mux));
			settle(frame + 1024);
			f0 = frameCount;
			settle(2 * frame);
			`CHECK("frames", 16'h0002, 16'(frameCount - f0))
			`CHECK("commons", mask, commonActive)
			`CHECK("common oe", mask | ~comDir, comPinOe)
		end
		for (int k = 0; k < 4; k++) begin
			`CHECK("row", {pix(3 * k + 2), pix(3 * k + 1), pix(3 * k)}, rowBits[k * 24 +: 24])
		end
	endtask

	// ----------------------------------------
	// Sequence and verdict
	// ----------------------------------------
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmpCount, failures);
		if (failures == 0 && cmpCount > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Planned run is near 60k cycles; a hang is cut well short of double that
	initial begin
		repeat (90000) @(posedge mclk);
		failures++;
		report_and_stop();
	end

	initial begin
		failures = 0;
		cmpCount = 0;
		sysRst = 1'b1;
		regWr = 1'b0;
		regRd = 1'b0;
		regAddr = 5'h00;
		regWdata = 8'h00;
		xtalCnt = 3'h0;
		lfCnt = 4'h0;
		xtalOsc = 1'b0;
		lfOsc = 1'b0;
		segDir = 24'hf0f0f0;
		comDir = 4'b1010;
		repeat (6) @(posedge mclk);
		sysRst <= 1'b0;
		settle(1);
		test_reset_and_map();
		test_pins();
		test_inactive();
		test_ladder();
		test_frames();
		report_and_stop();
	end

endmodule
